//--- src/dmac_params.svh
// Named widths and register-group indices for the multiply-accumulate macro.
// Assumes it is included by the package and by every design file.
`ifndef DMAC_PARAMS_SVH
`define DMAC_PARAMS_SVH
// Operand, half-operand, product, arithmetic, cascade and operation-control word widths
`define DMAC_OPW 18
`define DMAC_HW 9
`define DMAC_PW 36
`define DMAC_AW 54
`define DMAC_CW 55
`define DMAC_OPCW 9
// Clock-enable and reset groups, and lane count
`define DMAC_NGRP 4
`define DMAC_NLANE 2
`define DMAC_G_IN 0
`define DMAC_G_PIPE 1
`define DMAC_G_OUT 2
`define DMAC_G_SH 3
`endif

//--- src/dmac_pkg.sv
// Types shared by the multiply-accumulate macro and its multiplier lanes.
// Assumes dmac_params.svh is on the include path.
`include "dmac_params.svh"
package dmac_pkg;
  // Arithmetic unit operation select
  typedef enum logic [1:0] {
    ALU_PAB = 2'h0,
    ALU_PBC = 2'h1,
    ALU_ABC = 2'h2
  } dmac_alu_op_t;
  // Multiplier shapes
  typedef enum logic [1:0] {
    MUL_2X18 = 2'h0,
    MUL_18X36 = 2'h1,
    MUL_4X9 = 2'h2,
    MUL_36X36 = 2'h3
  } dmac_mul_mode_t;
  // Operation-control word, msb first
  typedef struct packed {
    dmac_alu_op_t alu_op;
    dmac_mul_mode_t mul_mode;
    logic use_prod;
    logic sub_g;
    logic sub_h;
    logic acc;
    logic chain;
  } dmac_opc_t;
  // Lane state: input, multiplier-input and product registers
  typedef struct packed {
    logic [`DMAC_OPW-1:0] a;
    logic [`DMAC_OPW-1:0] b;
    logic [`DMAC_OPW-1:0] pa;
    logic [`DMAC_OPW-1:0] pb;
    logic [`DMAC_PW-1:0] p;
  } dmac_lane_st_t;
  // Macro state
  typedef struct packed {
    logic [`DMAC_OPW-1:0] fsa;
    logic [`DMAC_OPW-1:0] fsb;
    logic [`DMAC_OPW-1:0] bso;
    logic [`DMAC_AW-1:0] c;
    dmac_opc_t opc;
    logic [`DMAC_AW-1:0] res;
    logic [`DMAC_AW-1:0] out;
  } dmac_top_st_t;
endpackage

//--- src/dmac_lane_if.sv
// Bundle between the macro top and one pre-adder/multiplier lane.
// Assumes the top drives every ctrl output each cycle.
`include "dmac_params.svh"
`timescale 1ns/1ps
`default_nettype none
interface dmac_lane_if;
  logic [`DMAC_OPW-1:0] a, b, fsh, bsh, a_q, b_q;
  logic sel_a, sel_b, sgn_a, sgn_b, sub, pre_en, pre9, mul9;
  logic in_reg, p1_reg, p2_reg, ld_in, clr_in, ld_pipe, clr_pipe;
  logic [`DMAC_PW-1:0] prod;
  // Macro side
  modport ctrl (output a, b, fsh, bsh, sel_a, sel_b, sgn_a, sgn_b, sub, pre_en, pre9,
    mul9, in_reg, p1_reg, p2_reg, ld_in, clr_in, ld_pipe, clr_pipe,
    input prod, a_q, b_q);
  // Lane side
  modport lane (input a, b, fsh, bsh, sel_a, sel_b, sgn_a, sgn_b, sub, pre_en, pre9,
    mul9, in_reg, p1_reg, p2_reg, ld_in, clr_in, ld_pipe, clr_pipe,
    output prod, a_q, b_q);
endinterface
`default_nettype wire

//--- src/dmac_lane.sv
// One pre-adder plus one 18x18 (or two 9x9) multiplier with optional registers.
// Assumes load and clear strobes come already resolved from the macro top.
`include "dmac_params.svh"
`timescale 1ns/1ps
`default_nettype none
module dmac_lane (
  input wire logic clk_sys, // Macro clock
  input wire logic rst_b, // Synchronous reset, active low
  dmac_lane_if.lane lif // Operands, config and product
);
  dmac_pkg::dmac_lane_st_t s_r, s_nxt;
  logic [`DMAC_OPW-1:0] a_in, b_in, x, y, pre, pw, ma, mb, m1a, m1b;
  logic [`DMAC_HW-1:0] ph, pl;
  logic [`DMAC_PW-1:0] prod_c, mh, ml;

  // Signed or unsigned product; sign flag extends the operand msb
  function automatic logic [`DMAC_PW-1:0] mulx(input logic [`DMAC_OPW-1:0] p,
      input logic [`DMAC_OPW-1:0] q, input logic sp, input logic sq);
    logic signed [`DMAC_OPW:0] ep;
    logic signed [`DMAC_OPW:0] eq;
    logic signed [2*`DMAC_OPW+1:0] r;
    ep = {sp & p[`DMAC_OPW-1], p};
    eq = {sq & q[`DMAC_OPW-1], q};
    r = ep * eq;
    return r[`DMAC_PW-1:0];
  endfunction

  // Half operand widened to a full operand
  function automatic logic [`DMAC_OPW-1:0] ext9(input logic [`DMAC_HW-1:0] v, input logic s);
    return {{`DMAC_HW{s & v[`DMAC_HW-1]}}, v};
  endfunction

  // Operand path, pre-adder, multiplier and register loads
  always_comb begin
    s_nxt = s_r;
    a_in = lif.in_reg ? s_r.a : lif.a;
    b_in = lif.in_reg ? s_r.b : lif.b;
    x = lif.sel_a ? lif.fsh : a_in;
    y = lif.sel_b ? lif.bsh : b_in;
    if (lif.sub) begin
      ph = x[`DMAC_OPW-1:`DMAC_HW] - y[`DMAC_OPW-1:`DMAC_HW];
      pl = x[`DMAC_HW-1:0] - y[`DMAC_HW-1:0];
      pw = x - y;
    end else begin
      ph = x[`DMAC_OPW-1:`DMAC_HW] + y[`DMAC_OPW-1:`DMAC_HW];
      pl = x[`DMAC_HW-1:0] + y[`DMAC_HW-1:0];
      pw = x + y;
    end
    // Narrow mode keeps the two halves apart, no carry between them
    pre = lif.pre9 ? {ph, pl} : pw;
    ma = lif.pre_en ? pre : x;
    mb = y;
    m1a = lif.p1_reg ? s_r.pa : ma;
    m1b = lif.p1_reg ? s_r.pb : mb;
    mh = mulx(ext9(m1a[`DMAC_OPW-1:`DMAC_HW], lif.sgn_a),
      ext9(m1b[`DMAC_OPW-1:`DMAC_HW], lif.sgn_b), lif.sgn_a, lif.sgn_b);
    ml = mulx(ext9(m1a[`DMAC_HW-1:0], lif.sgn_a),
      ext9(m1b[`DMAC_HW-1:0], lif.sgn_b), lif.sgn_a, lif.sgn_b);
    if (lif.mul9) begin
      prod_c = {mh[`DMAC_OPW-1:0], ml[`DMAC_OPW-1:0]};
    end else begin
      prod_c = mulx(m1a, m1b, lif.sgn_a, lif.sgn_b);
    end
    if (lif.clr_in) begin
      s_nxt.a = '0;
      s_nxt.b = '0;
    end else if (lif.ld_in) begin
      s_nxt.a = lif.a;
      s_nxt.b = lif.b;
    end
    if (lif.clr_pipe) begin
      s_nxt.pa = '0;
      s_nxt.pb = '0;
      s_nxt.p = '0;
    end else if (lif.ld_pipe) begin
      s_nxt.pa = ma;
      s_nxt.pb = mb;
      s_nxt.p = prod_c;
    end
  end

  // Product leaves through the output register or around it
  assign lif.prod = lif.p2_reg ? s_r.p : prod_c;
  assign lif.a_q = a_in;
  assign lif.b_q = b_in;

  // State register
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // Product register must still be selected when the result is looked at
  property p_mul_pipe;
    $past(rst_b, 2) && $past(rst_b) && lif.p2_reg
      && $past(lif.ld_pipe && lif.p1_reg && lif.p2_reg, 2) && $past(lif.ld_pipe && lif.p1_reg
      && lif.p2_reg && !lif.mul9 && !lif.clr_pipe) && !$past(lif.clr_pipe, 2)
      |-> lif.prod == mulx($past(ma, 2), $past(mb, 2), $past(lif.sgn_a), $past(lif.sgn_b));
  endproperty
  a_mul_pipe: assert property (p_mul_pipe)
    else $error("registered product not two cycles after operands");

  property p_unsigned;
    !lif.p1_reg && !lif.p2_reg && !lif.mul9 && !lif.sgn_a && !lif.sgn_b
      |-> lif.prod == `DMAC_PW'(`DMAC_PW'(m1a) * `DMAC_PW'(m1b));
  endproperty
  a_unsigned: assert property (p_unsigned)
    else $error("unsigned product wrong");

  property p_preadd;
    !lif.in_reg && !lif.sel_a && !lif.sel_b && lif.pre_en && !lif.pre9
      |-> ma == (lif.sub ? `DMAC_OPW'(lif.a - lif.b) : `DMAC_OPW'(lif.a + lif.b));
  endproperty
  a_preadd: assert property (p_preadd)
    else $error("pre-adder result wrong");
endmodule // dmac_lane
`default_nettype wire

//--- src/dmac_top.sv
// Multiply-accumulate macro: two lanes, 54-bit arithmetic unit, shift and cascade buses.
// Assumes fabric inputs and neighbour buses are synchronous to CLK_SYS.
`include "dmac_params.svh"
`timescale 1ns/1ps
`default_nettype none
module dmac_top (
  input wire logic CLK_SYS, // System clock
  input wire logic RST_B, // Synchronous reset, active low
  input wire logic [`DMAC_OPW-1:0] A0, // Operand A, lane 0
  input wire logic [`DMAC_OPW-1:0] B0, // Operand B, lane 0
  input wire logic [`DMAC_OPW-1:0] A1, // Operand A, lane 1
  input wire logic [`DMAC_OPW-1:0] B1, // Operand B, lane 1
  input wire logic [`DMAC_AW-1:0] C, // Third operand
  input wire logic [`DMAC_OPW-1:0] FWD_SHIFT_IN_A, // From previous macro
  input wire logic [`DMAC_OPW-1:0] FWD_SHIFT_IN_B, // From previous macro
  input wire logic [`DMAC_OPW-1:0] BACK_SHIFT_IN, // From next macro
  input wire logic [`DMAC_CW-1:0] CHAIN_SUM_IN, // Previous macro result
  input wire logic [`DMAC_NLANE-1:0] OPERAND_A_SOURCE_SELECT, // 1: forward shift
  input wire logic [`DMAC_NLANE-1:0] OPERAND_B_SOURCE_SELECT, // 1: back shift
  input wire logic [`DMAC_NLANE-1:0] OPERAND_A_SIGNED, // Per lane A sign
  input wire logic [`DMAC_NLANE-1:0] OPERAND_B_SIGNED, // Per lane B sign
  input wire logic [`DMAC_NLANE-1:0] PREADD_SUBTRACT_SELECT, // 1: subtract
  input wire logic [`DMAC_NLANE-1:0] PREADD_ENABLE, // Pre-adder feeds multiplier
  input wire logic [`DMAC_NLANE-1:0] PREADD_NARROW, // Two 9-bit pre-adds
  input wire logic [`DMAC_NLANE-1:0] IN_REG_EN, // Operand registers used
  input wire logic [`DMAC_NLANE-1:0] MUL_IN_REG_EN, // Multiplier input registers
  input wire logic [`DMAC_NLANE-1:0] MUL_OUT_REG_EN, // Product registers used
  input wire logic C_REG_EN, // C register used
  input wire logic ALU_OUT_REG_EN, // Extra result stage used
  input wire logic [`DMAC_OPCW-1:0] OPERATION_CONTROL, // Operation word
  input wire logic [`DMAC_NGRP-1:0] REG_CE, // Per-group load enable
  input wire logic [`DMAC_NGRP-1:0] REG_RESET, // Per-group clear, active high
  input wire logic [`DMAC_NGRP-1:0] RESET_ASYNC_MODE, // Clear ignores enable
  output logic [`DMAC_OPW-1:0] FWD_SHIFT_OUT_A, // To next macro
  output logic [`DMAC_OPW-1:0] FWD_SHIFT_OUT_B, // To next macro
  output logic [`DMAC_OPW-1:0] BACK_SHIFT_OUT, // To previous macro
  output logic [`DMAC_PW-1:0] DOUT, // Result low bits
  output logic [`DMAC_CW-1:0] CHAIN_SUM_OUT // Result to next macro
);
  dmac_pkg::dmac_top_st_t s_r, s_nxt;
  logic [`DMAC_NGRP-1:0] clr_g, ld_g;
  logic wide, ps0, ps1, chain_on;
  logic [`DMAC_AW-1:0] prod54, alu_a, alu_b, alu_c, f_op, g_op, h_op;
  logic [`DMAC_AW-1:0] core_c, chain_t, acc_t, res_c;

  dmac_lane_if lif [`DMAC_NLANE] ();

  // Widen a product or operand pair to the unit width
  function automatic logic [`DMAC_AW-1:0] ext36(input logic [`DMAC_PW-1:0] v, input logic s);
    return {{(`DMAC_AW-`DMAC_PW){s & v[`DMAC_PW-1]}}, v};
  endfunction

  // Widen one 9x9 product to the unit width
  function automatic logic [`DMAC_AW-1:0] ext18(input logic [`DMAC_OPW-1:0] v, input logic s);
    return {{(`DMAC_AW-`DMAC_OPW){s & v[`DMAC_OPW-1]}}, v};
  endfunction

  // Group strobes; async-mode clear does not wait for the enable
  assign clr_g = REG_RESET & (REG_CE | RESET_ASYNC_MODE);
  assign ld_g = REG_CE & ~clr_g;

  // Wide shapes borrow A0 into lane 1 and split B into {B1,B0}
  assign wide = (s_r.opc.mul_mode == dmac_pkg::MUL_18X36)
    || (s_r.opc.mul_mode == dmac_pkg::MUL_36X36);

  // Two identical lanes make up the macro
  for (genvar i = 0; i < `DMAC_NLANE; i++) begin : g_lane
    dmac_lane u_lane (
      .clk_sys(CLK_SYS),
      .rst_b(RST_B),
      .lif(lif[i])
    );
    assign lif[i].fsh = FWD_SHIFT_IN_A;
    assign lif[i].bsh = BACK_SHIFT_IN;
    assign lif[i].sel_a = OPERAND_A_SOURCE_SELECT[i];
    assign lif[i].sel_b = OPERAND_B_SOURCE_SELECT[i];
    assign lif[i].sub = PREADD_SUBTRACT_SELECT[i];
    assign lif[i].pre_en = PREADD_ENABLE[i];
    assign lif[i].pre9 = PREADD_NARROW[i];
    assign lif[i].mul9 = s_r.opc.mul_mode == dmac_pkg::MUL_4X9;
    assign lif[i].in_reg = IN_REG_EN[i];
    assign lif[i].p1_reg = MUL_IN_REG_EN[i];
    assign lif[i].p2_reg = MUL_OUT_REG_EN[i];
    assign lif[i].ld_in = ld_g[`DMAC_G_IN];
    assign lif[i].clr_in = clr_g[`DMAC_G_IN];
    assign lif[i].ld_pipe = ld_g[`DMAC_G_PIPE];
    assign lif[i].clr_pipe = clr_g[`DMAC_G_PIPE];
  end

  // Lane operands and signs; low half of a split B is always unsigned
  assign lif[0].a = A0;
  assign lif[1].a = wide ? A0 : A1;
  assign lif[0].b = B0;
  assign lif[1].b = B1;
  assign lif[0].sgn_a = OPERAND_A_SIGNED[0];
  assign lif[1].sgn_a = wide ? OPERAND_A_SIGNED[0] : OPERAND_A_SIGNED[1];
  assign lif[0].sgn_b = !wide && OPERAND_B_SIGNED[0];
  assign lif[1].sgn_b = OPERAND_B_SIGNED[1];
  assign ps0 = lif[0].sgn_a || lif[0].sgn_b;
  assign ps1 = lif[1].sgn_a || lif[1].sgn_b;

  // 36x36 upper macro always takes the lower macro through the chain
  assign chain_on = s_r.opc.chain || (s_r.opc.mul_mode == dmac_pkg::MUL_36X36);

  // Product term for each multiplier shape
  always_comb begin
    case (s_r.opc.mul_mode)
      dmac_pkg::MUL_2X18: begin
        prod54 = ext36(lif[0].prod, ps0) + ext36(lif[1].prod, ps1);
      end
      dmac_pkg::MUL_4X9: begin
        // Four products share one sum; the unit cannot hold them apart
        prod54 = ext18(lif[0].prod[`DMAC_PW-1:`DMAC_OPW], ps0)
          + ext18(lif[0].prod[`DMAC_OPW-1:0], ps0)
          + ext18(lif[1].prod[`DMAC_PW-1:`DMAC_OPW], ps1)
          + ext18(lif[1].prod[`DMAC_OPW-1:0], ps1);
      end
      dmac_pkg::MUL_18X36, dmac_pkg::MUL_36X36: begin
        prod54 = (ext36(lif[1].prod, ps1) << `DMAC_OPW) + ext36(lif[0].prod, ps0);
      end
      default: begin
        prod54 = '0;
      end
    endcase
  end

  // Unit operands; C goes through its register or around it
  assign alu_a = ext36({lif[1].a_q, lif[0].a_q}, OPERAND_A_SIGNED[1]);
  assign alu_b = ext36({lif[1].b_q, lif[0].b_q}, OPERAND_B_SIGNED[1]);
  assign alu_c = C_REG_EN ? s_r.c : C;

  // Operand routing for the three operations
  always_comb begin
    case (s_r.opc.alu_op)
      dmac_pkg::ALU_PAB: begin
        f_op = s_r.opc.use_prod ? prod54 : '0;
        g_op = alu_a;
        h_op = alu_b;
      end
      dmac_pkg::ALU_PBC: begin
        f_op = s_r.opc.use_prod ? prod54 : '0;
        g_op = alu_b;
        h_op = alu_c;
      end
      default: begin
        f_op = alu_a;
        g_op = alu_b;
        h_op = alu_c;
      end
    endcase
  end

  // Second sign applies only when A, B and C are all summed
  assign core_c = f_op
    + ((s_r.opc.alu_op == dmac_pkg::ALU_ABC && s_r.opc.sub_g) ? -g_op : g_op)
    + (s_r.opc.sub_h ? -h_op : h_op);
  assign chain_t = chain_on ? CHAIN_SUM_IN[`DMAC_AW-1:0] : '0;
  assign acc_t = s_r.opc.acc ? s_r.out : '0;
  assign res_c = core_c + chain_t + acc_t;

  // Register next values, group by group
  always_comb begin
    s_nxt = s_r;
    if (clr_g[`DMAC_G_OUT]) begin
      s_nxt.c = '0;
      s_nxt.opc = '0;
      s_nxt.res = '0;
      s_nxt.out = '0;
    end else if (ld_g[`DMAC_G_OUT]) begin
      s_nxt.c = C;
      s_nxt.opc = dmac_pkg::dmac_opc_t'(OPERATION_CONTROL);
      s_nxt.res = res_c;
      // Extra stage adds a cycle; the accumulator then sums a stale total
      s_nxt.out = ALU_OUT_REG_EN ? s_r.res : res_c;
    end
    // Shift buses ignore the enable so the hop is always one cycle
    if (clr_g[`DMAC_G_SH]) begin
      s_nxt.fsa = '0;
      s_nxt.fsb = '0;
      s_nxt.bso = '0;
    end else begin
      s_nxt.fsa = FWD_SHIFT_IN_A;
      s_nxt.fsb = FWD_SHIFT_IN_B;
      s_nxt.bso = lif[0].b_q;
    end
  end

  // State register
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from flops
  assign FWD_SHIFT_OUT_A = s_r.fsa;
  assign FWD_SHIFT_OUT_B = s_r.fsb;
  assign BACK_SHIFT_OUT = s_r.bso;
  assign DOUT = s_r.out[`DMAC_PW-1:0];
  assign CHAIN_SUM_OUT = {s_r.out[`DMAC_AW-1], s_r.out};

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);

  property p_fwd_a;
    $past(RST_B) && !$past(clr_g[`DMAC_G_SH]) |-> FWD_SHIFT_OUT_A == $past(FWD_SHIFT_IN_A);
  endproperty
  a_fwd_a: assert property (p_fwd_a)
    else $error("forward shift A not one cycle");

  property p_fwd_b;
    $past(RST_B) && !$past(clr_g[`DMAC_G_SH]) |-> FWD_SHIFT_OUT_B == $past(FWD_SHIFT_IN_B);
  endproperty
  a_fwd_b: assert property (p_fwd_b)
    else $error("forward shift B not one cycle");

  property p_chain_out;
    $past(RST_B) && $past(ld_g[`DMAC_G_OUT] && !ALU_OUT_REG_EN)
      |-> $signed(CHAIN_SUM_OUT) == $signed($past(res_c));
  endproperty
  a_chain_out: assert property (p_chain_out)
    else $error("cascade out not sign-extended result");

  property p_chain_in;
    $past(ld_g[`DMAC_G_OUT] && !ALU_OUT_REG_EN && !s_r.opc.acc && chain_on)
      |-> s_r.out == `DMAC_AW'($past(core_c) + $past(CHAIN_SUM_IN[`DMAC_AW-1:0]));
  endproperty
  a_chain_in: assert property (p_chain_in)
    else $error("cascade input not added");

  property p_acc;
    $past(ld_g[`DMAC_G_OUT] && !ALU_OUT_REG_EN && s_r.opc.acc && !chain_on)
      |-> s_r.out == `DMAC_AW'($past(s_r.out) + $past(core_c));
  endproperty
  a_acc: assert property (p_acc)
    else $error("accumulator did not add onto sum");

  property p_out_reg;
    $past(RST_B, 2) && $past(RST_B)
      && $past(ld_g[`DMAC_G_OUT] && ALU_OUT_REG_EN, 2) && $past(ld_g[`DMAC_G_OUT] && ALU_OUT_REG_EN)
      |-> s_r.out == $past(res_c, 2);
  endproperty
  a_out_reg: assert property (p_out_reg)
    else $error("registered result not two cycles late");

  property p_hold;
    $past(RST_B) && $past(!REG_CE[`DMAC_G_OUT] && !clr_g[`DMAC_G_OUT]) |-> $stable(DOUT);
  endproperty
  a_hold: assert property (p_hold)
    else $error("result moved without enable");

  property p_async_clr;
    $past(REG_RESET[`DMAC_G_OUT] && RESET_ASYNC_MODE[`DMAC_G_OUT]) |-> DOUT == '0;
  endproperty
  a_async_clr: assert property (p_async_clr)
    else $error("async-mode clear waited for enable");

  property p_opc;
    $past(RST_B) && $past(ld_g[`DMAC_G_OUT]) |-> s_r.opc == $past(OPERATION_CONTROL);
  endproperty
  a_opc: assert property (p_opc)
    else $error("operation word not captured");

  // Backward bus carries the lane 0 B operand one hop later
  property p_back_out;
    $past(RST_B) && !$past(clr_g[`DMAC_G_SH]) |-> BACK_SHIFT_OUT == $past(lif[0].b_q);
  endproperty
  a_back_out: assert property (p_back_out)
    else $error("backward shift out not one cycle");

  // Shift clear needs the enable or async mode; once it fires it must land
  property p_sh_clr;
    $past(RST_B && clr_g[`DMAC_G_SH])
      |-> FWD_SHIFT_OUT_A == '0 && FWD_SHIFT_OUT_B == '0 && BACK_SHIFT_OUT == '0;
  endproperty
  a_sh_clr: assert property (p_sh_clr)
    else $error("shift buses not cleared");

  c_acc: cover property (ld_g[`DMAC_G_OUT] && s_r.opc.acc ##1 ld_g[`DMAC_G_OUT]);
  c_mul9: cover property (s_r.opc.mul_mode == dmac_pkg::MUL_4X9 && ld_g[`DMAC_G_OUT]);
  c_wide: cover property (s_r.opc.mul_mode == dmac_pkg::MUL_36X36 && ld_g[`DMAC_G_OUT]);
  c_narrow: cover property (ld_g[`DMAC_G_OUT] && PREADD_NARROW != '0 && PREADD_ENABLE != '0);
  c_shift_src: cover property (OPERAND_A_SOURCE_SELECT != '0 && OPERAND_B_SOURCE_SELECT != '0);
endmodule // dmac_top
`default_nettype wire

//--- testbench/dmac_nbr_model.sv
// Neighbour macros around the macro under test: shift buses and cascade sum.
// Assumes one shared clock; values move just after each rising edge.
`timescale 1ns/1ps
`default_nettype none
module dmac_nbr_model (
  input wire logic clk, // Shared clock
  input wire logic rst_b, // Sync reset, active low
  output logic [17:0] sh_a, // Previous macro forward shift A
  output logic [17:0] sh_b, // Previous macro forward shift B
  output logic [17:0] sh_back, // Next macro backward shift
  output logic [54:0] chain // Previous macro cascade sum
);
  logic [53:0] v_r;
  // New word every edge, so a stuck pass-through cannot hide
  always_ff @(posedge clk) begin
    if (!rst_b) v_r <= 54'h2a5c3e19b07d4;
    else v_r <= v_r * 54'h5 + 54'h3b9;
  end
  // Shift words and sign-extended cascade word
  assign sh_a = v_r[17:0];
  assign sh_b = v_r[35:18];
  assign sh_back = v_r[53:36] ^ 18'h2aaaa;
  assign chain = {v_r[53], v_r};
endmodule // dmac_nbr_model
`default_nettype wire

//--- testbench/dmac_top_test.sv
// Self-checking bench for the multiply-accumulate macro, all paths on one clock.
// Assumes the neighbour model file is compiled first.
`timescale 1ns/1ps
`default_nettype none
module dmac_top_test;
  typedef struct {int m; logic [53:0] r; logic [17:0] sa, sb, bo;} dmac_ent_t;
  logic clk, rst_b, cre, aore;
  logic [17:0] av [2], bv [2], fsa, fsb, bsi, fsa_o, fsb_o, bso_o;
  logic [53:0] c, res_q;
  logic [54:0] cin, cout;
  logic [35:0] dout;
  logic [1:0] asg, bsg, psub, pen, ire, mire, more, asel, operand_b_source_select, pnar;
  logic [8:0] opc, opc_q;
  logic [3:0] ce, rr, am;
  logic [31:0] seed, tmp;
  logic [8:0] ops [12] = '{9'h014, 9'h090, 9'h094, 9'h100, 9'h108, 9'h10c,
    9'h030, 9'h050, 9'h012, 9'h012, 9'h070, 9'h011};
  int errors, check_count;
  dmac_ent_t q [$];
  dmac_ent_t e;
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  dmac_nbr_model nbr_u (.clk(clk), .rst_b(rst_b), .sh_a(fsa), .sh_b(fsb),
    .sh_back(bsi), .chain(cin));
  dmac_top dut_u (
    .CLK_SYS(clk), .RST_B(rst_b), .A0(av[0]), .B0(bv[0]), .A1(av[1]), .B1(bv[1]),
    .C(c), .FWD_SHIFT_IN_A(fsa), .FWD_SHIFT_IN_B(fsb), .BACK_SHIFT_IN(bsi),
    .CHAIN_SUM_IN(cin), .OPERAND_A_SOURCE_SELECT(asel), .OPERAND_B_SOURCE_SELECT(operand_b_source_select),
    .OPERAND_A_SIGNED(asg), .OPERAND_B_SIGNED(bsg), .PREADD_SUBTRACT_SELECT(psub),
    .PREADD_ENABLE(pen), .PREADD_NARROW(pnar), .IN_REG_EN(ire), .MUL_IN_REG_EN(mire),
    .MUL_OUT_REG_EN(more), .C_REG_EN(cre), .ALU_OUT_REG_EN(aore),
    .OPERATION_CONTROL(opc), .REG_CE(ce), .REG_RESET(rr), .RESET_ASYNC_MODE(am),
    .FWD_SHIFT_OUT_A(fsa_o), .FWD_SHIFT_OUT_B(fsb_o), .BACK_SHIFT_OUT(bso_o),
    .DOUT(dout), .CHAIN_SUM_OUT(cout));
  // Stimulus source: shift register sequence
  function automatic logic [31:0] nr();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [53:0] s18(input logic s, input logic [17:0] v);
    return s ? {{36{v[17]}}, v} : {36'h0, v};
  endfunction
  function automatic logic [53:0] s36(input logic s, input logic [35:0] v);
    return s ? {{18{v[35]}}, v} : {18'h0, v};
  endfunction
  // Reference result for one loaded edge under operation word o
  function automatic logic [53:0] calc(input logic [8:0] o);
    logic [53:0] p, ta, tb, t2, r;
    logic [17:0] x, xi, yi;
    p = 54'h0;
    for (int i = 0; i < 2; i++) begin
      xi = asel[i] ? fsa : av[i];
      yi = operand_b_source_select[i] ? bsi : bv[i];
      x = psub[i] ? xi - yi : xi + yi;
      if (pnar[i]) x = psub[i] ? {9'(xi[17:9] - yi[17:9]), 9'(xi[8:0] - yi[8:0])}
        : {9'(xi[17:9] + yi[17:9]), 9'(xi[8:0] + yi[8:0])};
      if (!pen[i]) x = xi;
      p = p + s18(asg[i], x) * s18(bsg[i], yi);
    end
    // Wide shapes: lane 1 borrows A0, so the unit's A term repeats A0
    if (o[5]) p = av[0] * {bv[1], bv[0]};
    if (o[6:5] == 2'h2) p = av[0][17:9] * bv[0][17:9] + av[0][8:0] * bv[0][8:0]
      + av[1][17:9] * bv[1][17:9] + av[1][8:0] * bv[1][8:0];
    ta = s36(asg[1], {o[5] ? av[0] : av[1], av[0]});
    tb = s36(bsg[1], {bv[1], bv[0]});
    if (o[8:7] == 2'h2) return ta + (o[3] ? -tb : tb) + (o[2] ? -c : c);
    t2 = o[7] ? c : tb;
    r = (o[4] ? p : 54'h0) + (o[7] ? tb : ta) + (o[2] ? -t2 : t2);
    r = r + (o[1] ? res_q : 54'h0);
    return r + ((o[0] || o[6:5] == 2'h3) ? cin[53:0] : 54'h0);
  endfunction
  task automatic rand_ops;
    for (int i = 0; i < 2; i++) begin
      tmp = nr();
      av[i] = tmp[17:0];
      tmp = nr();
      bv[i] = tmp[17:0];
    end
    c[31:0] = nr();
    tmp = nr();
    c[53:32] = tmp[21:0];
  endtask
  // Note the outcome of the next edge; m 0 forward shifts only, 2 expects the old result
  task automatic step(input int m);
    dmac_ent_t n;
    logic [53:0] r;
    n.m = m;
    n.sa = rr[3] ? 18'h0 : fsa;
    n.sb = rr[3] ? 18'h0 : fsb;
    n.bo = rr[3] ? 18'h0 : bv[0];
    r = res_q;
    if (rr[2] && (ce[2] || am[2])) begin
      r = 54'h0;
      opc_q = 9'h0;
    end else if (ce[2]) begin
      r = calc(opc_q);
      opc_q = opc;
    end
    n.r = (m == 2) ? res_q : r;
    res_q = r;
    q.push_back(n);
    @(negedge clk);
  endtask
  task automatic cmp(input logic bad, input string msg);
    check_count++;
    if (bad) begin
      errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic tally_and_finish;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Output watcher: one noted outcome per edge, oldest first
  always @(posedge clk) begin
    #1;
    if (q.size() > 0) begin
      e = q.pop_front();
      cmp(fsa_o !== e.sa, "forward shift a");
      cmp(fsb_o !== e.sb, "forward shift b");
      if (e.m != 0) cmp(dout !== e.r[35:0], "dout");
      if (e.m != 0) cmp(cout !== {e.r[53], e.r}, "chain out");
      if (e.m == 1) cmp(bso_o !== e.bo, "back shift out");
    end
  end
  // Watchdog, far beyond the roughly fifty cycles the sequence needs
  initial begin
    #100us;
    errors++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    seed = 32'h0ee4492b;
    rst_b = 1'b0;
    av = '{18'h0, 18'h0};
    bv = '{18'h0, 18'h0};
    {c, res_q, asg, bsg, psub, pen, ire, mire, more, cre, aore} = '0;
    {opc, opc_q, rr, am, asel, operand_b_source_select, pnar} = '0;
    ce = 4'hf;
    errors = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    cmp(dout !== 36'h0, "reset dout");
    cmp(cout !== 55'h0, "reset chain");
    rst_b = 1'b1;
    opc = 9'h010;
    for (int k = 0; k < 10; k++) begin
      asg = (k < 5) ? 2'h0 : 2'h3;
      bsg = (k < 5) ? 2'h0 : 2'h3;
      rand_ops();
      step(1);
    end
    {asg, bsg} = 4'h0;
    foreach (ops[k]) begin
      opc = ops[k];
      rand_ops();
      step(1);
    end
    // Pre-adder over both operand sources, full and split widths
    opc = 9'h010;
    pen = 2'h3;
    for (int s = 0; s < 4; s++) begin
      psub = s[1:0];
      pnar = {s[1], s[1]};
      asel = {s[0], 1'b0};
      operand_b_source_select = {1'b0, s[0]};
      tmp = nr();
      av = '{{2'h1, tmp[15:0]}, {2'h1, tmp[31:16]}};
      tmp = nr();
      bv = '{{3'h0, tmp[14:0]}, {3'h0, tmp[30:16]}};
      step(1);
    end
    {pen, asel, operand_b_source_select, pnar} = 8'h0;
    // Enable hold, clear regardless of enable, shift clear
    ce = 4'hb;
    rand_ops();
    step(1);
    rr = 4'h4;
    am = 4'h4;
    step(1);
    {ce, rr, am} = {4'hf, 4'h8, 4'h0};
    step(1);
    rr = 4'h0;
    step(1);
    // All register stages on: old result for one edge, five unchecked edges, then the new one
    {ire, mire, more, cre, aore} = 8'hff;
    repeat (6) step(0);
    rand_ops();
    step(2);
    repeat (5) step(0);
    step(1);
    {ire, mire, more, cre, aore} = 8'h0;
    repeat (3) step(0);
    step(1);
    repeat (2) @(posedge clk);
    tally_and_finish();
  end
endmodule // dmac_top_test
`default_nettype wire
